// ### prft_top.sv
/*
  Power-fail ride-through supervisor: times a supply outage, raises the
  undervoltage, control-power drop and main-circuit drop alarms, and drives
  fault, warning, ride-through, torque-limit, level-select and brake outputs.
  Assumes supply_loss, bus_undervoltage and main_drop_detect are clean levels
  synchronous to sys_clk, and that main_drop_detect already compares the bus
  against the level chosen by alt_level_select.
*/
// The register addresses and register access over Avalon-MM were decided locally.
module prft_top import prft_pkg::*; #(
  parameter int unsigned TICK_CYCLES = PRFT_MS_CYCLES,
  parameter int unsigned DETECT_W = PRFT_DETECT_W
) (
  input wire logic sys_clk, // 25 MHz system clock
  input wire logic rstn, // Async reset, active low
  input wire logic [PRFT_ADDR_W-1:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [PRFT_DATA_W-1:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [PRFT_DATA_W-1:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Wait request
  input wire logic supply_loss, // Supply monitor: power lost
  input wire logic bus_undervoltage, // Bus at or below 158 V DC
  input wire logic main_drop_detect, // Bus below selected drop level
  output logic ride_through_active, // Ride-through in progress
  output logic brake_interlock, // Brake release permitted
  output logic fault_output, // Any alarm latched
  output logic warning_output, // Outage being ridden through
  output logic torque_limit_active, // Torque limited for outage
  output logic alt_level_select // Alternative drop level in use
);

  localparam int unsigned AW = $bits(prft_alarm_t);

  // Byte-lane merge for register writes
  function automatic logic [PRFT_DATA_W-1:0] merge_be(
    input logic [PRFT_DATA_W-1:0] old_val,
    input logic [PRFT_DATA_W-1:0] new_val,
    input logic [3:0] be
  );
    logic [PRFT_DATA_W-1:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = new_val[8*i +: 8];
      end
    end
    return res;
  endfunction

  prft_state_t st_reg;
  prft_state_t st_next;
  prft_cfg_t cfg_reg;
  prft_cfg_t cfg_next;
  prft_alarm_t alarm_reg;
  prft_alarm_t alarm_next;
  prft_alarm_t alarm_evt;
  prft_alarm_t alarm_clr;
  prft_acc_t acc;
  logic [DETECT_W-1:0] ms_cnt_reg;
  logic [DETECT_W-1:0] ms_cnt_next;
  logic ms_tick;
  logic riding;
  logic in_ride_next;
  logic any_alarm_next;
  logic outage_expired;
  logic loss_no_ride;
  logic wr_ctrl;
  logic wr_detect;
  logic wr_alarm;
  logic [PRFT_DATA_W-1:0] ctrl_word;
  logic [PRFT_DATA_W-1:0] ctrl_merged;
  logic [PRFT_DATA_W-1:0] detect_merged;
  logic [PRFT_DATA_W-1:0] status_word;
  logic [PRFT_DATA_W-1:0] rd_word;
  logic ride_reg;
  logic brake_reg;
  logic fault_reg;
  logic warn_reg;
  logic torque_reg;
  logic level_reg;

  // Bus handshake and read-data register
  prft_avs u_avs (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .rd_word(rd_word),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .acc(acc)
  );

  // Outage timebase, runs only while riding through
  prft_ms_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .run(riding),
    .tick(ms_tick)
  );

  // Write decode
  assign wr_ctrl = acc.wr && (acc.addr == PRFT_CTRL_OFS);
  assign wr_detect = acc.wr && (acc.addr == PRFT_DETECT_OFS);
  assign wr_alarm = acc.wr && (acc.addr == PRFT_ALARM_OFS);

  assign ctrl_word = {{(PRFT_DATA_W-2){1'b0}}, cfg_reg.torque_sel, cfg_reg.ride_sel};
  assign ctrl_merged = merge_be(ctrl_word, acc.data, acc.be);
  assign detect_merged = merge_be({{(PRFT_DATA_W-DETECT_W){1'b0}}, cfg_reg.detect_ms},
                                  acc.data, acc.be);

  always_comb begin
    cfg_next = cfg_reg;
    if (wr_ctrl) begin
      cfg_next.ride_sel = ctrl_merged[PRFT_CTRL_RIDE_BIT];
      cfg_next.torque_sel = ctrl_merged[PRFT_CTRL_TORQUE_BIT];
    end
    if (wr_detect) begin
      cfg_next.detect_ms = detect_merged[DETECT_W-1:0];
    end
  end

  // Ride-through state
  assign riding = (st_reg == PRFT_RIDE);

  // outage longer than the set time
  assign outage_expired = riding && supply_loss && (ms_cnt_reg >= cfg_reg.detect_ms);
  // loss with ride-through off alarms at once
  assign loss_no_ride = (st_reg == PRFT_IDLE) && supply_loss && !cfg_reg.ride_sel;

  assign alarm_evt.undervolt = bus_undervoltage;
  assign alarm_evt.ctrl_drop = outage_expired || loss_no_ride;
  assign alarm_evt.main_drop = main_drop_detect;

  // Write-one-to-clear; a new event beats the clear
  assign alarm_clr = wr_alarm ? prft_alarm_t'(acc.data[AW-1:0] & {AW{acc.be[0]}})
                              : prft_alarm_t'('0);
  assign alarm_next = prft_alarm_t'((alarm_reg & ~alarm_clr) | alarm_evt);
  assign any_alarm_next = |alarm_next;

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      PRFT_IDLE: begin
        if (any_alarm_next) begin
          st_next = PRFT_ALARM;
        end else if (supply_loss && cfg_reg.ride_sel) begin
          st_next = PRFT_RIDE;
        end
      end
      PRFT_RIDE: begin
        if (any_alarm_next) begin
          st_next = PRFT_ALARM;
        end else if (!supply_loss) begin
          // supply back in time, no alarm
          st_next = PRFT_IDLE;
        end
      end
      PRFT_ALARM: begin
        if (!any_alarm_next && !supply_loss) begin
          st_next = PRFT_IDLE;
        end
      end
    endcase
  end

  // Elapsed outage time in whole milliseconds
  always_comb begin
    ms_cnt_next = ms_cnt_reg;
    if (!riding) begin
      ms_cnt_next = '0;
    end else if (ms_tick && (ms_cnt_reg != {DETECT_W{1'b1}})) begin
      ms_cnt_next = ms_cnt_reg + 1'b1;
    end
  end

  // Output values one cycle ahead of the state
  assign in_ride_next = (st_next == PRFT_RIDE);

  // Register read mux
  assign status_word = {{(PRFT_DATA_W-8){1'b0}}, st_reg == PRFT_ALARM, level_reg,
                        torque_reg, warn_reg, fault_reg, brake_reg, ride_reg,
                        supply_loss};

  always_comb begin
    rd_word = '0;
    unique case (avs_address)
      PRFT_CTRL_OFS: rd_word = ctrl_word;
      PRFT_DETECT_OFS: rd_word = {{(PRFT_DATA_W-DETECT_W){1'b0}}, cfg_reg.detect_ms};
      PRFT_STATUS_OFS: rd_word = status_word;
      PRFT_ALARM_OFS: rd_word = {{(PRFT_DATA_W-AW){1'b0}}, alarm_reg};
      PRFT_ELAPSED_OFS: rd_word = {{(PRFT_DATA_W-DETECT_W){1'b0}}, ms_cnt_reg};
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= PRFT_IDLE;
      cfg_reg.ride_sel <= PRFT_RIDE_SEL_RST;
      cfg_reg.torque_sel <= PRFT_TORQUE_SEL_RST;
      cfg_reg.detect_ms <= DETECT_W'(PRFT_DETECT_MS_RST);
      alarm_reg <= '0;
      ms_cnt_reg <= '0;
    end else begin
      st_reg <= st_next;
      cfg_reg <= cfg_next;
      alarm_reg <= alarm_next;
      ms_cnt_reg <= ms_cnt_next;
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ride_reg <= 1'b0;
      brake_reg <= 1'b1;
      fault_reg <= 1'b0;
      warn_reg <= 1'b0;
      torque_reg <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      ride_reg <= in_ride_next;
      brake_reg <= !any_alarm_next;
      fault_reg <= any_alarm_next;
      warn_reg <= in_ride_next;
      torque_reg <= in_ride_next && cfg_reg.torque_sel;
      level_reg <= in_ride_next;
    end
  end

  assign ride_through_active = ride_reg;
  assign brake_interlock = brake_reg;
  assign fault_output = fault_reg;
  assign warning_output = warn_reg;
  assign torque_limit_active = torque_reg;
  assign alt_level_select = level_reg;

endmodule // prft_top

// ### prft_pkg.sv
/*
  Shared constants and types for the power-fail ride-through supervisor.
  Assumes a single 25 MHz system clock and an Avalon-MM register port.
*/
package prft_pkg;

  // Clock and time base
  localparam int unsigned PRFT_CLK_PERIOD_NS = 40;
  localparam int unsigned PRFT_MS_IN_NS = 1000000;
  localparam int unsigned PRFT_MS_CYCLES = PRFT_MS_IN_NS / PRFT_CLK_PERIOD_NS;

  // Detection time setting
  localparam int unsigned PRFT_DETECT_W = 16;
  localparam logic [15:0] PRFT_DETECT_MS_RST = 16'h00C8;

  // Bus geometry
  localparam int unsigned PRFT_ADDR_W = 5;
  localparam int unsigned PRFT_DATA_W = 32;

  // Register byte offsets
  localparam logic [4:0] PRFT_CTRL_OFS = 5'h00;
  localparam logic [4:0] PRFT_DETECT_OFS = 5'h04;
  localparam logic [4:0] PRFT_STATUS_OFS = 5'h08;
  localparam logic [4:0] PRFT_ALARM_OFS = 5'h0C;
  localparam logic [4:0] PRFT_ELAPSED_OFS = 5'h10;

  // Control register fields and reset values
  localparam int unsigned PRFT_CTRL_RIDE_BIT = 0;
  localparam int unsigned PRFT_CTRL_TORQUE_BIT = 1;
  localparam logic PRFT_RIDE_SEL_RST = 1'b0;
  localparam logic PRFT_TORQUE_SEL_RST = 1'b0;

  // Alarm register fields
  localparam int unsigned PRFT_ALM_UV_BIT = 0;
  localparam int unsigned PRFT_ALM_CTRL_BIT = 1;
  localparam int unsigned PRFT_ALM_MAIN_BIT = 2;

  typedef enum logic [1:0] {PRFT_IDLE, PRFT_RIDE, PRFT_ALARM} prft_state_t;

  typedef struct packed {
    logic [PRFT_DETECT_W-1:0] detect_ms;
    logic torque_sel;
    logic ride_sel;
  } prft_cfg_t;

  typedef struct packed {
    logic main_drop;
    logic ctrl_drop;
    logic undervolt;
  } prft_alarm_t;

  typedef struct packed {
    logic wr;
    logic [PRFT_ADDR_W-1:0] addr;
    logic [PRFT_DATA_W-1:0] data;
    logic [3:0] be;
  } prft_acc_t;

endpackage

// ### prft_ms_tick.sv
/*
  Millisecond tick generator for the outage timer.
  Assumes run is a registered level; the count restarts whenever run is low.
*/
module prft_ms_tick import prft_pkg::*; #(
  parameter int unsigned TICK_CYCLES = PRFT_MS_CYCLES
) (
  input wire logic sys_clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic run, // Counting enable level
  output logic tick // One-cycle pulse per period
);

  localparam int unsigned CW = $clog2(TICK_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic at_last;

  assign at_last = (cnt_reg == LAST);
  assign cnt_next = (!run || at_last) ? '0 : cnt_reg + 1'b1;
  assign tick = run && at_last;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule // prft_ms_tick

// ### prft_avs.sv
/*
  Avalon-MM slave handshake: one wait cycle on every access.
  Assumes the master holds its request until it sees waitrequest low.
*/
module prft_avs import prft_pkg::*; (
  input wire logic sys_clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic [PRFT_ADDR_W-1:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [PRFT_DATA_W-1:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  input wire logic [PRFT_DATA_W-1:0] rd_word, // Decoded read value
  output logic [PRFT_DATA_W-1:0] avs_readdata, // Registered read data
  output logic avs_waitrequest, // Registered wait
  output prft_acc_t acc // Write strobe with data
);

  logic wait_reg;
  logic wait_next;
  logic [PRFT_DATA_W-1:0] rdata_reg;
  logic [PRFT_DATA_W-1:0] rdata_next;
  logic req;
  logic take;

  assign req = avs_read || avs_write;
  assign take = req && !wait_reg;
  assign wait_next = !(req && wait_reg);
  // Read word caught while waitrequest is still high
  assign rdata_next = (avs_read && wait_reg) ? rd_word : rdata_reg;

  assign acc.wr = avs_write && take;
  assign acc.addr = avs_address;
  assign acc.data = avs_writedata;
  assign acc.be = avs_byteenable;
  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wait_reg <= 1'b1;
      rdata_reg <= '0;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

endmodule // prft_avs

// ### prft_top_assertions.sv
/* Port checker for the ride-through supervisor.
   Assumes it is bound onto prft_top, one clock domain. */
module prft_chk import prft_pkg::*; (
  input wire logic sys_clk, // Clock
  input wire logic rstn, // Reset
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic avs_waitrequest, // Wait
  input wire logic supply_loss, // Loss
  input wire logic bus_undervoltage, // Sag
  input wire logic ride_through_active, // Ride
  input wire logic brake_interlock, // Brake
  input wire logic fault_output, // Fault
  input wire logic warning_output, // Warn
  input wire logic torque_limit_active, // Torque
  input wire logic alt_level_select // Level
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_bus_wait: assert property (s_req |=> s_ack)
    else $error("bus answer late");
  a_ride_brake: assert property (ride_through_active |-> brake_interlock)
    else $error("brake off in ride");
  a_alarm_brake: assert property (fault_output |-> !brake_interlock)
    else $error("brake on with alarm");
  a_uv_fault: assert property (bus_undervoltage |=> fault_output)
    else $error("undervoltage missed");
  a_level_ride: assert property (alt_level_select == ride_through_active)
    else $error("level select wrong");
  a_ride_cause: assert property ($rose(ride_through_active) |-> $past(supply_loss))
    else $error("ride without loss");
  a_ride_ends: assert property (ride_through_active && !supply_loss |=> !ride_through_active)
    else $error("ride not ended");
  a_fault_ride: assert property (fault_output |-> !ride_through_active && !torque_limit_active)
    else $error("ride during alarm");
  a_torque_ride: assert property (torque_limit_active |-> ride_through_active)
    else $error("torque limit outside ride");
  a_warn_mirror: assert property (warning_output == ride_through_active)
    else $error("warning differs");
endmodule // prft_chk

bind prft_top prft_chk prft_chk_inst (
  .sys_clk, .rstn, .avs_read, .avs_write, .avs_waitrequest, .supply_loss,
  .bus_undervoltage, .ride_through_active, .brake_interlock, .fault_output,
  .warning_output, .torque_limit_active, .alt_level_select
);

// ### prft_supply_model.sv
/* Model of the supply and bus monitors feeding the supervisor.
   Assumes bench commands change just after a rising edge. */
module prft_supply_model import prft_pkg::*; (
  input wire logic sys_clk, // Clock
  input wire logic rstn, // Reset
  input wire logic outage, // Command: supply off
  input wire logic sag, // Command: bus undervoltage
  input wire logic [1:0] bus_lvl, // 0 ok, 1 below normal, 2 below both
  input wire logic alt_level_select, // Level choice
  output logic supply_loss, // Supply lost
  output logic bus_undervoltage, // Undervoltage flag
  output logic main_drop_detect // Below chosen level
);
  logic drop_now;
  assign drop_now = alt_level_select ? (bus_lvl == 2'h2) : (bus_lvl != 2'h0);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      supply_loss <= 1'b0;
      bus_undervoltage <= 1'b0;
      main_drop_detect <= 1'b0;
    end else begin
      supply_loss <= outage;
      bus_undervoltage <= sag;
      main_drop_detect <= drop_now;
    end
  end
endmodule // prft_supply_model

// ### prft_top_tb.sv
/* Self-checking bench for the ride-through supervisor.
   Assumes a 4-cycle millisecond so outages stay short. */
module prft_top_tb import prft_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rstn = 0, rd = 0, wr = 0, outage = 0, sag = 0;
  logic [1:0] lvl = 0;
  logic [4:0] adr = 0;
  logic [31:0] wd = 0, q;
  wire logic [31:0] rdata;
  wire logic wt, sl, uv, md, ride, brk, flt, wrn, trq, alt;
  int fail_count = 0, checked = 0, n;
  prft_top #(.TICK_CYCLES(4)) prft_top_inst (.sys_clk, .rstn, .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF),
    .avs_readdata(rdata), .avs_waitrequest(wt), .supply_loss(sl),
    .bus_undervoltage(uv), .main_drop_detect(md), .ride_through_active(ride),
    .brake_interlock(brk), .fault_output(flt), .warning_output(wrn),
    .torque_limit_active(trq), .alt_level_select(alt));
  prft_supply_model prft_supply_model_inst (.sys_clk, .rstn, .outage, .sag,
    .bus_lvl(lvl), .alt_level_select(alt), .supply_loss(sl),
    .bus_undervoltage(uv), .main_drop_detect(md));
  initial forever #20 sys_clk = ~sys_clk;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (wt === 1'b0) break;
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (i == 20) begin
      fail_count++;
      tally_and_finish;
    end
  endtask
  initial begin
    cyc(2);
    rstn <= 1'b1;
    acc(0, PRFT_CTRL_OFS, 0);
    chk(q, 32'h0);
    acc(0, PRFT_DETECT_OFS, 0);
    chk(q, 32'hC8);
    acc(0, 5'h14, 0);
    chk(q, 32'h0);
    chk(brk, 1'b1);
    $display("reset test done");
    outage <= 1'b1;
    cyc(4);
    chk(flt, 1'b1);
    chk(ride, 1'b0);
    outage <= 1'b0;
    acc(0, PRFT_ALARM_OFS, 0);
    chk(q, 32'h2);
    acc(1, PRFT_ALARM_OFS, 32'h7);
    acc(0, PRFT_ALARM_OFS, 0);
    chk(q, 32'h0);
    $display("disabled test done");
    acc(1, PRFT_CTRL_OFS, 32'h3);
    acc(1, PRFT_DETECT_OFS, 32'h2);
    outage <= 1'b1;
    cyc(3);
    lvl <= 2'h1;
    cyc(2);
    chk(ride, 1'b1);
    chk(trq, 1'b1);
    chk(alt, 1'b1);
    chk(brk, 1'b1);
    chk(flt, 1'b0);
    chk(wrn, 1'b1);
    acc(0, PRFT_STATUS_OFS, 0);
    chk(q, 32'h77);
    outage <= 1'b0;
    lvl <= 2'h0;
    cyc(3);
    chk(ride, 1'b0);
    chk(brk, 1'b1);
    acc(0, PRFT_ALARM_OFS, 0);
    chk(q, 32'h0);
    $display("short outage test done");
    outage <= 1'b1;
    n = 0;
    while (flt !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    if (n == 40) begin
      fail_count++;
      tally_and_finish;
    end
    chk(n >= 10 && n <= 14, 1'b1);
    chk(brk, 1'b0);
    chk(ride, 1'b0);
    outage <= 1'b0;
    acc(0, PRFT_ALARM_OFS, 0);
    chk(q, 32'h2);
    acc(1, PRFT_ALARM_OFS, 32'h2);
    acc(0, PRFT_ALARM_OFS, 0);
    chk(q, 32'h0);
    $display("long outage test done");
    outage <= 1'b1;
    cyc(3);
    sag <= 1'b1;
    cyc(3);
    chk(flt, 1'b1);
    chk(ride, 1'b0);
    outage <= 1'b0;
    sag <= 1'b0;
    acc(0, PRFT_ALARM_OFS, 0);
    chk(q[0], 1'b1);
    acc(1, PRFT_ALARM_OFS, 32'h7);
    $display("undervoltage test done");
    lvl <= 2'h1;
    cyc(4);
    lvl <= 2'h0;
    acc(0, PRFT_ALARM_OFS, 0);
    chk(q, 32'h4);
    acc(1, PRFT_ALARM_OFS, 32'h7);
    acc(0, PRFT_ALARM_OFS, 0);
    chk(q, 32'h0);
    $display("main drop test done");
    tally_and_finish;
  end
endmodule // prft_top_tb
